//--- rtl/crb_fifo.sv
`timescale 1ns/100ps

module crb_fifo
	import crb_pkg::*;
#(
	parameter int W = 30,
	parameter int D = 32
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_word,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_word
);

	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW + 1)'(D);

	// pointers wrap naturally, so D must be a power of two
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wr;
		logic [AW-1:0]       rd;
		logic [AW:0]         cnt;
	} crb_fifo_state_t;

	crb_fifo_state_t st;
	crb_fifo_state_t next_st;
	logic            push;
	logic            pop;

	assign in_ready  = (st.cnt != FULL);
	assign out_valid = (st.cnt != '0);
	assign out_word  = st.mem[st.rd];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr] = in_word;
			next_st.wr         = st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = st.rd + 1'b1;
		end
		unique case ({push, pop})
			2'b10: next_st.cnt = st.cnt + 1'b1;
			2'b01: next_st.cnt = st.cnt - 1'b1;
			2'b00,
			2'b11: next_st.cnt = st.cnt;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule : crb_fifo

//--- rtl/crb_pkg.sv
package crb_pkg;

	// one sample of the controller-side pins
	typedef struct packed {
		logic        cs_primary;
		logic        cs_secondary;
		logic        odt;
		logic        cke;
		logic [24:0] data;
	} crb_pins_t;

	// the two static configuration selects
	typedef struct packed {
		logic width;
		logic arrangement;
	} crb_cfg_t;

	// one captured word as it travels through the buffer
	typedef struct packed {
		logic        hold;
		logic        wide;
		logic        cs;
		logic        odt;
		logic        cke;
		logic [24:0] data;
	} crb_word_t;

	// complete state of the top module, except the fifo state held in u_fifo
	typedef struct packed {
		crb_pins_t   pin_s1;
		crb_pins_t   pin_s2;
		crb_cfg_t    cfg_s1;
		crb_cfg_t    cfg_s2;
		logic [1:0]  wake;
		logic        rx_en;
		logic        wide;
		logic [24:0] q_data;
		logic        q_cs;
		logic        q_odt;
		logic        q_cke;
	} crb_state_t;

endpackage : crb_pkg

//--- rtl/crb_regs.svh
`ifndef CRB_REGS_SVH
`define CRB_REGS_SVH

// widths of the register paths and the fifo depth
`define CRB_DATA_W          25
`define CRB_PAIR_W          14
`define CRB_FIFO_DEPTH      32

// data-input masks per configuration, bit n-1 is input n
`define CRB_MASK_1TO1       25'h1FFFFB6
`define CRB_MASK_PAIR_A     25'h0003FB6
`define CRB_MASK_PAIR_B     25'h0001BBF

// reset values
`define CRB_DATA_RST        25'h0000000
`define CRB_BIT_RST         1'h0
`define CRB_WAKE_RST        2'h0

// timing
`define CRB_CLK_PERIOD_NS   100
`define CRB_CLK_HZ          10000000
`define CRB_MAX_CLK_HZ      450000000
`define CRB_RX_WAKE_NS      200
`define CRB_RX_WAKE_CYCLES  ((`CRB_RX_WAKE_NS + `CRB_CLK_PERIOD_NS - 1) / `CRB_CLK_PERIOD_NS)

`endif

//--- rtl/crb_top.sv
`timescale 1ns/100ps
`include "crb_regs.svh"

module crb_top
	import crb_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        width_select,
	input  wire logic        arrangement_select,
	input  wire logic        primary_chip_select_in,
	input  wire logic        secondary_chip_select_in,
	input  wire logic [24:0] data_in,
	input  wire logic        termination_ctrl_in,
	input  wire logic        clock_enable_ctrl_in,
	output logic             capture_ready,
	input  wire logic        drain_ready,
	output logic [24:0]      gated_data_out,
	output logic [13:0]      gated_data_out_a,
	output logic [13:0]      gated_data_out_b,
	output logic             chip_select_out,
	output logic             chip_select_out_a,
	output logic             chip_select_out_b,
	output logic             termination_ctrl_out,
	output logic             termination_ctrl_out_a,
	output logic             termination_ctrl_out_b,
	output logic             clock_enable_ctrl_out,
	output logic             clock_enable_ctrl_out_a,
	output logic             clock_enable_ctrl_out_b
);

	localparam int          WORD_W = $bits(crb_word_t);
	localparam logic [1:0]  WAKE_LAST = 2'(`CRB_RX_WAKE_CYCLES - 1);
	localparam logic [24:0] MASK_ONE = `CRB_MASK_1TO1;
	localparam logic [24:0] MASK_A   = `CRB_MASK_PAIR_A;
	localparam logic [24:0] MASK_B   = `CRB_MASK_PAIR_B;
	localparam logic [13:0] PAIR_ZERO = 14'h0000;
	localparam logic [24:0] ONE_ZERO  = `CRB_DATA_RST;

	crb_state_t st;
	crb_state_t next_st;
	crb_pins_t  pins;
	crb_cfg_t   cfg;
	crb_word_t  cap_word;
	crb_word_t  drain_word;
	logic       cap_valid;
	logic       cap_ready;
	logic       drain_valid;
	logic       drain_take;

	// mask of inputs that the configuration really uses
	function automatic logic [24:0] crb_used_mask(
		input logic wide,
		input logic arrangement
	);
		logic [24:0] m;
		m = MASK_ONE;
		if (wide) begin
			m = arrangement ? MASK_B : MASK_A;
		end
		return m;
	endfunction : crb_used_mask

	always_comb begin
		pins.cs_primary   = primary_chip_select_in;
		pins.cs_secondary = secondary_chip_select_in;
		pins.odt          = termination_ctrl_in;
		pins.cke          = clock_enable_ctrl_in;
		pins.data         = data_in;
		cfg.width         = width_select;
		cfg.arrangement   = arrangement_select;
	end

	// captured word, built only from the second synchroniser stage
	always_comb begin
		cap_word.hold = st.pin_s2.cs_primary & st.pin_s2.cs_secondary;
		cap_word.wide = st.cfg_s2.width;
		cap_word.cs   = st.pin_s2.cs_primary;
		cap_word.odt  = st.pin_s2.odt;
		cap_word.cke  = st.pin_s2.cke;
		cap_word.data = st.pin_s2.data &
			crb_used_mask(st.cfg_s2.width, st.cfg_s2.arrangement);
	end

	// no capture until receivers are awake
	assign cap_valid     = st.rx_en;
	assign capture_ready = cap_ready;
	assign drain_take    = drain_valid & drain_ready;

	crb_fifo #(
		.W (WORD_W),
		.D (`CRB_FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.in_valid  (cap_valid),
		.in_ready  (cap_ready),
		.in_word   (cap_word),
		.out_valid (drain_valid),
		.out_ready (drain_ready),
		.out_word  (drain_word)
	);

	always_comb begin
		next_st = st;
		next_st.pin_s1 = pins;
		next_st.pin_s2 = st.pin_s1;
		next_st.cfg_s1 = cfg;
		next_st.cfg_s2 = st.cfg_s1;

		if (!st.rx_en) begin
			next_st.wake = st.wake + 1'b1;
			if (st.wake == WAKE_LAST) begin
				next_st.rx_en = 1'b1;
			end
		end

		if (drain_take) begin
			next_st.wide = drain_word.wide;
			next_st.q_cs  = drain_word.cs;
			next_st.q_odt = drain_word.odt;
			next_st.q_cke = drain_word.cke;
			if (!drain_word.hold) begin
				next_st.q_data = drain_word.data;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// outputs are pure fan-out of the registered word;
	// the side not selected by width sits low
	always_comb begin
		// reset clears the flops feeding every output
		gated_data_out          = ONE_ZERO;
		gated_data_out_a        = PAIR_ZERO;
		gated_data_out_b        = PAIR_ZERO;
		chip_select_out         = 1'b0;
		chip_select_out_a       = 1'b0;
		chip_select_out_b       = 1'b0;
		termination_ctrl_out    = 1'b0;
		termination_ctrl_out_a  = 1'b0;
		termination_ctrl_out_b  = 1'b0;
		clock_enable_ctrl_out   = 1'b0;
		clock_enable_ctrl_out_a = 1'b0;
		clock_enable_ctrl_out_b = 1'b0;
		if (st.wide) begin
			gated_data_out_a        = st.q_data[13:0];
			gated_data_out_b        = st.q_data[13:0];
			chip_select_out_a       = st.q_cs;
			chip_select_out_b       = st.q_cs;
			termination_ctrl_out_a  = st.q_odt;
			termination_ctrl_out_b  = st.q_odt;
			clock_enable_ctrl_out_a = st.q_cke;
			clock_enable_ctrl_out_b = st.q_cke;
		end else begin
			gated_data_out        = st.q_data;
			chip_select_out       = st.q_cs;
			termination_ctrl_out  = st.q_odt;
			clock_enable_ctrl_out = st.q_cke;
		end
	end

	// layout A and layout B reach the pairs via the mask
	// single-cycle paths only, no multicycle logic

endmodule : crb_top

//--- sim/crb_dram_model.sv
`timescale 1ns/100ps

module crb_dram_model
	import crb_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] pace,
	output logic            drain_ready
);
	logic tog;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tog <= 1'h0;
		end else begin
			tog <= !tog;
		end
	end
	// pace 0 prompt, 1 every other cycle, 2 stopped
	assign drain_ready = pace == 2'h0 || (pace == 2'h1 && tog);
endmodule : crb_dram_model

//--- sim/crb_top_bench.sv
`timescale 1ns/100ps

module crb_top_bench;
	import crb_pkg::*;
	logic        sys_clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        width_select = 1'h0;
	logic        arrangement_select = 1'h0;
	logic        primary_chip_select_in = 1'h0;
	logic        secondary_chip_select_in = 1'h0;
	logic [24:0] data_in = 25'h0;
	logic        termination_ctrl_in = 1'h0;
	logic        clock_enable_ctrl_in = 1'h0;
	logic [1:0]  pace = 2'h0;
	logic [24:0] gated_data_out;
	logic [13:0] gated_data_out_a, gated_data_out_b;
	logic        capture_ready, drain_ready, chip_select_out;
	logic        chip_select_out_a, chip_select_out_b, termination_ctrl_out;
	logic        termination_ctrl_out_a, termination_ctrl_out_b;
	logic        clock_enable_ctrl_out, clock_enable_ctrl_out_a;
	logic        clock_enable_ctrl_out_b;
	logic [24:0] mask [3] = '{25'h1FFFFB6, 25'h0003FB6, 25'h0001BBF};
	int          miscompares = 0;
	int          checks_done = 0;

	always #50 sys_clk = ~sys_clk;
	crb_top i_dut (.*);
	crb_dram_model i_dram (.*);

	task automatic check(input logic [24:0] got, input logic [24:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// c is {width, arrangement, primary, secondary}
	task automatic put(input logic [3:0] c, input logic [24:0] d, int n);
		@(posedge sys_clk);
		{width_select, arrangement_select} <= c[3:2];
		{primary_chip_select_in, secondary_chip_select_in} <= c[1:0];
		data_in <= d;
		{termination_ctrl_in, clock_enable_ctrl_in} <= d[1:0];
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : put

	task automatic give_verdict();
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		// selects driven, reset held low through start
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'h1;
		put(4'h0, 25'h0, 4);
		check(gated_data_out, 25'h0);
		for (int m = 0; m < 3; m++) begin
			put({m != 0, m == 2, 2'h0}, 25'h1FFFFFF, 4);
			check(m == 0 ? gated_data_out : 25'(gated_data_out_a), mask[m]);
			check(25'(gated_data_out_b), m == 0 ? 25'h0 : mask[m]);
			check(25'({termination_ctrl_out, termination_ctrl_out_a}),
				m == 0 ? 25'h2 : 25'h1);
			check(25'({clock_enable_ctrl_out, clock_enable_ctrl_out_a,
				clock_enable_ctrl_out_b, termination_ctrl_out_b}),
				m == 0 ? 25'h8 : 25'h7);
		end
		// arrangement bit set in 1:1 must not change the mask
		put(4'h4, 25'h1FFFFFF, 4);
		put(4'h3, 25'h0, 4);
		check(gated_data_out, mask[0]);
		check(25'({chip_select_out, termination_ctrl_out}), 25'h2);
		put(4'h2, 25'h0, 4);
		check(gated_data_out, 25'h0);
		@(posedge sys_clk);
		pace <= 2'h2;
		put(4'h0, 25'h1FFFFFF, 3);
		put(4'h0, 25'h0, 36);
		check(25'(capture_ready), 25'h0);
		check(gated_data_out, 25'h0);
		@(posedge sys_clk);
		pace <= 2'h1;
		for (int i = 0; i < 80 && gated_data_out === 25'h0; i++) begin
			@(posedge sys_clk);
			#1;
		end
		check(gated_data_out, mask[0]);
		@(posedge sys_clk);
		pace <= 2'h0;
		put(4'h3, 25'h0, 4);
		// mid-cycle entry, data_in left floating
		#20 rst_n <= 1'h0;
		data_in <= 'z;
		#1 check(gated_data_out, 25'h0);
		repeat (3) @(posedge sys_clk);
		#1 check(25'({chip_select_out, termination_ctrl_out}), 25'h0);
		put(4'h0, 25'h0, 2);
		rst_n <= 1'h1;
		put(4'h0, 25'h1FFFFFF, 4);
		check(gated_data_out, mask[0]);
		give_verdict();
	end

	initial begin
		// tests take about 115 cycles
		#(1000 * 100);
		miscompares++;
		give_verdict();
	end
endmodule : crb_top_bench

//--- sim/crb_top_monitor.sv
`timescale 1ns/100ps
`include "crb_regs.svh"

module crb_top_monitor
	import crb_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        width_select,
	input wire logic        primary_chip_select_in,
	input wire logic        secondary_chip_select_in,
	input wire logic [24:0] data_in,
	input wire logic        drain_ready,
	input wire logic [24:0] gated_data_out,
	input wire logic [13:0] gated_data_out_a,
	input wire logic [13:0] gated_data_out_b,
	input wire logic        chip_select_out,
	input wire logic        chip_select_out_a,
	input wire logic        chip_select_out_b,
	input wire logic        termination_ctrl_out,
	input wire logic        termination_ctrl_out_a,
	input wire logic        termination_ctrl_out_b,
	input wire logic        clock_enable_ctrl_out_a,
	input wire logic        clock_enable_ctrl_out_b
);
	logic [2:0] age;
	logic       stalled;
	logic       ok;

	// latency is fixed only while no stall has left a backlog
	assign ok = age == 3'h7 && !stalled;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			age     <= 3'h0;
			stalled <= 1'h0;
		end else begin
			age     <= age + {2'h0, age != 3'h7};
			stalled <= stalled | !drain_ready;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	property p_first;
		$rose(rst_n) |-> {gated_data_out, gated_data_out_a,
			chip_select_out, termination_ctrl_out} == 41'h0;
	endproperty
	a_first: assert property (p_first)
		else $error("outputs not low after reset");
	property p_pair;
		gated_data_out_a == gated_data_out_b &&
			chip_select_out_a == chip_select_out_b &&
			termination_ctrl_out_a == termination_ctrl_out_b &&
			clock_enable_ctrl_out_a == clock_enable_ctrl_out_b;
	endproperty
	a_pair: assert property (p_pair)
		else $error("paired copies differ");
	property p_mode;
		gated_data_out_a != 14'h0 |-> gated_data_out == 25'h0;
	endproperty
	a_mode: assert property (p_mode)
		else $error("both widths active");
	property p_mask;
		(gated_data_out & ~`CRB_MASK_1TO1) == 25'h0;
	endproperty
	a_mask: assert property (p_mask)
		else $error("unused output bit set");
	property p_stall;
		!drain_ready |=> $stable(gated_data_out) && $stable(chip_select_out);
	endproperty
	a_stall: assert property (p_stall)
		else $error("outputs moved without capture");
	property p_cs;
		ok |-> (chip_select_out | chip_select_out_a) ==
			$past(primary_chip_select_in, 4);
	endproperty
	a_cs: assert property (p_cs)
		else $error("select output not following");
	property p_hold;
		ok && $past(primary_chip_select_in & secondary_chip_select_in, 4)
			|-> $stable(gated_data_out) && $stable(gated_data_out_a);
	endproperty
	a_hold: assert property (p_hold)
		else $error("gated outputs changed while held");
	property p_upd;
		ok && !$past(width_select, 4) &&
			!$past(primary_chip_select_in & secondary_chip_select_in, 4)
			|-> gated_data_out == ($past(data_in, 4) & `CRB_MASK_1TO1);
	endproperty
	a_upd: assert property (p_upd)
		else $error("gated outputs not updated");
endmodule : crb_top_monitor

bind crb_top crb_top_monitor i_mon (.*);
